// ---- src/adc_parallel_host_port.sv ----
// Design decisions made here: the register offsets and the AHB-Lite register port.
`timescale 1ns/10ps
module adc_parallel_host_port import adc_port_pkg::*; #(
    parameter int CHANNELS = CH_N,
    parameter int CONV_CNT = CONV_CYCLES
) (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic irq,
    // Host pins and strap.
    input wire host_in_type host_pins,
    output logic [BUS_W-1:0] result_bus_out,
    output logic result_bus_oe_n,
    output logic busy_n,
    input wire logic mode_pin,
    // Converter front end.
    input wire logic [BUS_W-1:0] conv_result,
    output front_type front
);

    localparam int CNT_W = $clog2(CONV_CNT + 1);
    localparam logic [CH_W-1:0] ADDR_MASK = CH_W'(CHANNELS - 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CONV_CNT - 1);

    typedef struct packed {
        host_in_type s1;
        host_in_type s2;
        host_in_type s3;
        logic strap1;
        logic strap2;
        logic [1:0] strap_cnt;
        mode_type mode;
        logic [CHANNELS-1:0] configured;
        logic [CHANNELS-1:0] pend_pair;
        logic [CHANNELS-1:0] pend_signed;
        logic [CHANNELS-1:0] eff_pair;
        logic [CHANNELS-1:0] eff_signed;
        logic [CHANNELS-1:0] scan;
        logic [CHANNELS-1:0][BUS_W-1:0] ram;
        logic sleep;
        logic busy;
        logic drive;
        conv_state_type st;
        logic [CH_W-1:0] ch;
        logic [CH_W-1:0] slot;
        logic [CH_W-1:0] ptr;
        logic [CNT_W-1:0] cnt;
        logic [BUS_W-1:0] rd_data;
        logic [1:0] wired_cfg;
        logic [IRQ_W-1:0] status;
        logic [IRQ_W-1:0] mask;
        logic wr_pend;
        logic [7:0] waddr;
        logic [31:0] rdata;
        front_type fr;
    } core_type;

    core_type q;
    core_type d;
    logic wr_fall;
    logic wr_rise;
    logic rd_fall;
    logic [CH_W-1:0] wr_addr;
    logic [IRQ_W-1:0] ev_set;
    logic [IRQ_W-1:0] ev_clr;

    // Lowest set channel of a scan set; used at start and after each channel.
    function automatic logic [CH_W-1:0] next_ch(input logic [CHANNELS-1:0] set);
        logic [CH_W-1:0] r;
        r = '0;
        for (int i = CHANNELS - 1; i >= 0; i--) begin
            if (set[i]) begin
                r = CH_W'(i);
            end
        end
        return r;
    endfunction

    // Strobe edges seen only after two synchroniser stages; the rise takes chip select
    // from the stage before, since select may lift together with the strobe.
    always_comb begin
        wr_fall = q.s3.wr_n && !q.s2.wr_n && !q.s2.cs_n;
        wr_rise = !q.s3.wr_n && q.s2.wr_n && !q.s3.cs_n;
        rd_fall = q.s3.rd_n && !q.s2.rd_n && !q.s2.cs_n;
        wr_addr = q.s3.bus[CH_W-1:0] & ADDR_MASK;
    end

    // Next state of the whole block.
    always_comb begin
        logic [CHANNELS-1:0] set;
        logic [CHANNELS-1:0] rem;
        logic addr_ok;
        set = '0;
        rem = '0;
        addr_ok = hsel && hready && htrans[1];
        ev_set = '0;
        ev_clr = '0;
        d = q;
        d.s1 = host_pins;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.strap1 = mode_pin;
        d.strap2 = q.strap1;

        // The strap is taken once, a few cycles after reset release, then held.
        if (q.strap_cnt != STRAP_DONE) begin
            d.strap_cnt = q.strap_cnt + 2'h1;
        end
        if (q.strap_cnt == STRAP_TAKE) begin
            d.mode = mode_type'(q.strap2);
        end

        // Falling write edge freezes every hold at once and rewinds a multichannel read.
        d.fr.hold = wr_fall;
        if (wr_fall && !q.s2.bus[BIT_SUPPRESS] && (!q.s2.bus[BIT_ALL] || q.mode == MODE_WIRED)) begin
            d.ptr = '0;
        end

        // Rising write edge loads configuration and may start a conversion.
        if (wr_rise) begin
            d.sleep = q.s3.bus[BIT_SLEEP];
            if (q.s3.bus[BIT_SUPPRESS]) begin
                d.ptr = wr_addr;
            end
            if (q.mode == MODE_HOST && (q.s3.bus[BIT_SUPPRESS] || q.s3.bus[BIT_ALL])) begin
                d.configured[wr_addr] = 1'b1;
                d.pend_pair[wr_addr] = q.s3.bus[BIT_PAIR];
                d.pend_signed[wr_addr] = q.s3.bus[BIT_SIGNED];
            end
            if (!q.s3.bus[BIT_SUPPRESS]) begin
                if (q.busy) begin
                    ev_set[IRQ_OVERRUN] = 1'b1;
                end else begin
                    if (q.mode == MODE_WIRED) begin
                        set = '1;
                        d.eff_pair = {CHANNELS{q.wired_cfg[WIRED_PAIR_BIT]}};
                        d.eff_signed = {CHANNELS{q.wired_cfg[WIRED_SIGNED_BIT]}};
                    end else begin
                        // Old pending values apply now; this write's take the next turn.
                        d.eff_pair = q.pend_pair;
                        d.eff_signed = q.pend_signed;
                        if (q.s3.bus[BIT_ALL]) begin
                            set = '0;
                            set[wr_addr] = 1'b1;
                            d.ptr = wr_addr;
                        end else begin
                            set = q.configured;
                        end
                    end
                    if (set != '0) begin
                        d.busy = 1'b1;
                        d.st = ST_CONV;
                        d.scan = set;
                        d.ch = next_ch(set);
                        d.cnt = '0;
                        d.slot = (q.mode == MODE_HOST && q.s3.bus[BIT_ALL]) ? wr_addr : '0;
                    end else begin
                        ev_set[IRQ_DONE] = 1'b1;
                    end
                end
            end
        end

        // Channel by channel conversion; results fill memory in scan order.
        if (q.st == ST_CONV) begin
            if (q.cnt == CNT_LAST) begin
                rem = q.scan;
                rem[q.ch] = 1'b0;
                d.ram[q.slot] = conv_result;
                d.scan = rem;
                d.ch = next_ch(rem);
                d.slot = (q.slot + CH_W'(1)) & ADDR_MASK;
                d.cnt = '0;
                if (rem == '0) begin
                    d.st = ST_IDLE;
                    d.busy = 1'b0;
                    ev_set[IRQ_DONE] = 1'b1;
                end
            end else begin
                d.cnt = q.cnt + CNT_W'(1);
            end
        end

        // Host read: the word is latched on the falling strobe, the pointer steps when it ends.
        if (rd_fall) begin
            d.rd_data = q.ram[q.ptr];
            d.drive = 1'b1;
        end else if (q.drive && (q.s2.rd_n || q.s2.cs_n)) begin
            d.drive = 1'b0;
            d.ptr = (q.ptr + CH_W'(1)) & ADDR_MASK;
        end

        // AHB-Lite: address phase captured, read data prepared for the data phase.
        d.wr_pend = addr_ok && hwrite;
        d.waddr = haddr[7:0];
        if (addr_ok && !hwrite) begin
            d.rdata = '0;
            if (haddr[7:0] == OFF_STATUS) begin
                d.rdata[IRQ_W-1:0] = q.status;
            end else if (haddr[7:0] == OFF_MASK) begin
                d.rdata[IRQ_W-1:0] = q.mask;
            end else if (haddr[7:0] == OFF_STATE) begin
                d.rdata[ST_BUSY_BIT] = q.busy;
                d.rdata[ST_MODE_BIT] = q.mode;
                d.rdata[ST_SLEEP_BIT] = q.sleep;
                d.rdata[ST_PTR_LSB +: CH_W] = q.ptr;
                d.rdata[ST_CFG_LSB +: CHANNELS] = q.configured;
            end else if (haddr[7:0] == OFF_WIRED) begin
                d.rdata[1:0] = q.wired_cfg;
            end else if (haddr[7:0] >= OFF_RESULT && haddr[7:0] < OFF_RESULT + 8'(4 * CHANNELS)) begin
                d.rdata[BUS_W-1:0] = q.ram[haddr[CH_W+1:2]];
            end
        end
        if (q.wr_pend) begin
            if (q.waddr == OFF_STATUS) begin
                ev_clr = hwdata[IRQ_W-1:0];
            end else if (q.waddr == OFF_MASK) begin
                d.mask = hwdata[IRQ_W-1:0];
            end else if (q.waddr == OFF_WIRED) begin
                d.wired_cfg = hwdata[1:0];
            end
        end
        // A new event outranks a clear written in the same cycle.
        d.status = (q.status & ~ev_clr) | ev_set;

        d.fr.channel = d.ch;
        d.fr.pair = d.eff_pair[d.ch];
        d.fr.signed_rng = d.eff_signed[d.ch];
        d.fr.sleep = d.sleep;
    end

    // One register bank; strobe stages reset to the idle, deselected level.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
            q.s1 <= HOST_IDLE;
            q.s2 <= HOST_IDLE;
            q.s3 <= HOST_IDLE;
        end else begin
            q <= d;
        end
    end

    // Outputs, all from registers or constants apart from the interrupt gate.
    assign hrdata = q.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign irq = |(q.status & q.mask);
    assign result_bus_out = q.rd_data;
    assign result_bus_oe_n = ~q.drive;
    assign busy_n = ~q.busy;
    assign front = q.fr;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_busy_conv_low: assert property ((q.st == ST_CONV) |-> !busy_n)
        else $error("busy released during conversion");
    a_busy_end_count: assert property ($rose(busy_n) |-> $past(q.cnt) == CNT_LAST)
        else $error("busy ended before full conversion time");
    a_start_on_rise: assert property (wr_rise && !q.s3.bus[BIT_SUPPRESS] && !q.busy && q.mode == MODE_HOST
        && q.s3.bus[BIT_ALL] |=> !busy_n && $onehot(q.scan))
        else $error("single channel start did not begin conversion");
    a_suppress_idle: assert property (wr_rise && q.s3.bus[BIT_SUPPRESS] && !q.busy |=> busy_n)
        else $error("suppressed write started conversion");
    a_hold_fall: assert property (wr_fall |=> front.hold ##1 !front.hold)
        else $error("hold pulse not tied to write falling edge");
    a_deselect_float: assert property (q.s2.cs_n |=> result_bus_oe_n)
        else $error("bus driven while deselected");
    a_read_data: assert property (rd_fall |=> !result_bus_oe_n && result_bus_out == $past(q.ram[q.ptr]))
        else $error("read returned wrong memory word");
    a_ptr_step: assert property (q.drive && q.s2.rd_n && !wr_fall && !wr_rise
        |=> q.ptr == (($past(q.ptr) + CH_W'(1)) & ADDR_MASK))
        else $error("read pointer did not advance");
    a_ptr_rewind: assert property (wr_fall && !q.s2.bus[BIT_SUPPRESS] && !q.s2.bus[BIT_ALL] |=> q.ptr == '0)
        else $error("pointer not rewound for multichannel write");
    a_deferred_cfg: assert property (wr_rise && !q.s3.bus[BIT_SUPPRESS] && !q.busy && q.mode == MODE_HOST
        |=> q.eff_pair == $past(q.pend_pair))
        else $error("pair selection applied too early");
    a_mode_kept: assert property (q.strap_cnt == STRAP_DONE |=> $stable(q.mode))
        else $error("mode changed after strap capture");
    a_deferred_signed: assert property (wr_rise && !q.s3.bus[BIT_SUPPRESS] && !q.busy && q.mode == MODE_HOST
        |=> q.eff_signed == $past(q.pend_signed))
        else $error("range selection applied too early");
    a_drive_in_read: assert property (!result_bus_oe_n |-> !q.s3.rd_n && !q.s3.cs_n)
        else $error("bus driven outside a selected read");
    a_wired_all: assert property (wr_rise && !q.s3.bus[BIT_SUPPRESS] && !q.busy && q.mode == MODE_WIRED
        |=> q.scan == '1)
        else $error("wired start did not take every channel");
    a_all_configured: assert property (wr_rise && !q.s3.bus[BIT_SUPPRESS] && !q.busy && q.mode == MODE_HOST
        && !q.s3.bus[BIT_ALL] |=> q.scan == $past(q.configured))
        else $error("multichannel start missed configured channels");

endmodule

// ---- src/adc_port_pkg.sv ----
// Contract
// - Read and write strobes count only while chip select is low.
// - Each read strobe returns the next stored result from result memory.
// - Write strobe rising edge latches channel configuration and starts conversion.
// - Write strobe falling edge samples all inputs into their holds at once.
// - Busy output stays low for the whole conversion, high after it ends.
// - Strapped mode pin selects host-programmed or fixed wired configuration.
// - Bus bit 7 is result MSB on reads, all/single selector on writes.
// - Bus bit 6 is a result bit, or the differential selector on writes.
// - Bus bit 5 is a result bit, or the bipolar range selector on writes.
// - Bus bit 4 is a result bit, or the conversion suppress flag on writes.
// - Bus bit 3 is a result bit, or the power-down request on writes.
// - Bus bits 2..0 are result bits, or memory address; top bit eight-channel only.
// - Bus lines are driven only during a selected read, floating otherwise.
// - Read pointer steps per read, returns to 0 when multichannel write falls.
// - Selector 0 converts all configured channels; 1 converts only the addressed one.
// - Differential and bipolar changes apply from the following conversion on.
// - Suppress 1 loads configuration or address only; 0 starts on rising edge.
package adc_port_pkg;

    // Bus and channel geometry.
    localparam int BUS_W = 8;
    localparam int CH_N = 8;
    localparam int CH_W = 3;

    // Conversion time per channel, rounded up to whole clock cycles.
    localparam int CLK_PERIOD_NS = 20;
    localparam int CONV_TIME_NS = 3600;
    localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Meaning of the shared bus bits on a write.
    localparam int BIT_ALL = 7;
    localparam int BIT_PAIR = 6;
    localparam int BIT_SIGNED = 5;
    localparam int BIT_SUPPRESS = 4;
    localparam int BIT_SLEEP = 3;

    // Register byte offsets on the AHB-Lite side.
    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_MASK = 8'h04;
    localparam logic [7:0] OFF_STATE = 8'h08;
    localparam logic [7:0] OFF_WIRED = 8'h0C;
    localparam logic [7:0] OFF_RESULT = 8'h20;

    // Interrupt status bits.
    localparam int IRQ_W = 2;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_OVERRUN = 1;

    // Fields of the state register.
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_MODE_BIT = 1;
    localparam int ST_SLEEP_BIT = 2;
    localparam int ST_PTR_LSB = 4;
    localparam int ST_CFG_LSB = 8;

    // Fields of the wired configuration register.
    localparam int WIRED_PAIR_BIT = 0;
    localparam int WIRED_SIGNED_BIT = 1;

    // Strap capture sequence after reset release.
    localparam logic [1:0] STRAP_TAKE = 2'h2;
    localparam logic [1:0] STRAP_DONE = 2'h3;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_CONV = 1'b1
    } conv_state_type;

    typedef enum logic [0:0] {
        MODE_HOST = 1'b0,
        MODE_WIRED = 1'b1
    } mode_type;

    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic [BUS_W-1:0] bus;
    } host_in_type;

    typedef struct packed {
        logic hold;
        logic sleep;
        logic pair;
        logic signed_rng;
        logic [CH_W-1:0] channel;
    } front_type;

    localparam host_in_type HOST_IDLE = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, bus: '0};

endpackage

// ---- tb/host_model.sv ----
`timescale 1ns/10ps
// Host processor on the shared bus; it steps its strobes in whole hclk cycles.
module host_model import adc_port_pkg::*; (
    // Clock.
    input wire logic hclk,
    // Pins toward the device.
    output host_in_type pins,
    input wire logic [BUS_W-1:0] dev_bus,
    input wire logic dev_oe_n
);
    host_in_type hp = HOST_IDLE;

    // The device wins the lines while it drives them; otherwise the host value shows.
    assign pins = '{cs_n: hp.cs_n, rd_n: hp.rd_n, wr_n: hp.wr_n, bus: dev_oe_n ? hp.bus : dev_bus};

    // Every level is held six cycles, above the three that the synchronisers need.
    task automatic gap();
        repeat (6) @(posedge hclk);
    endtask

    // One write strobe, framed by chip select when cs_n is low.
    task automatic wr(input logic [BUS_W-1:0] b, input logic cs_n);
        @(posedge hclk);
        hp.cs_n <= cs_n;
        hp.bus <= b;
        gap();
        hp.wr_n <= 1'b0;
        gap();
        hp.wr_n <= 1'b1;
        gap();
        hp.cs_n <= 1'b1;
        hp.bus <= ~b; // Released lines must not keep showing the written byte.
        gap();
    endtask

    // One read strobe; the byte is taken while the strobe is still low.
    task automatic rd(output logic [BUS_W-1:0] d);
        @(posedge hclk);
        hp.cs_n <= 1'b0;
        gap();
        hp.rd_n <= 1'b0;
        gap();
        d = pins.bus;
        hp.rd_n <= 1'b1;
        gap();
        hp.cs_n <= 1'b1;
        gap();
    endtask
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/10ps
module tb import adc_port_pkg::*; ;
    localparam int CC = 4;
    localparam int CEIL = 6000;
    localparam int CHANNELS_ALL = CH_N;
    typedef struct packed {
        logic [7:0] wb;
        logic [3:0] n;
        logic [3:0] loc;
        logic [7:0] exp;
        logic pr;
        logic sg;
    } row_type;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0, hwrite = 1'b0, mode_pin = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdat;
    logic hreadyout, hresp, irq, oe_n, busy_n;
    logic [7:0] res_out, d;
    logic [7:0] conv_result = 8'h00;
    host_in_type pins;
    front_type front;
    int error_cnt = 0, checked = 0, cyc = 0, busy_cyc = 0, hold_cnt = 0, pair_cyc = 0, b0, h0, p0;
    int sig_cyc = 0, s0;
    // Single, pair-delayed, suppressed and all-configured starts in order.
    // The last column marks the signed range, loaded for channel 1 and seen only in the multichannel run.
    row_type rows [6] = '{'{8'h80, 4'h1, 4'h0, 8'hA0, 1'b0, 1'b0}, '{8'hA1, 4'h1, 4'h1, 8'hA1, 1'b0, 1'b0},
        '{8'hC2, 4'h1, 4'h2, 8'hA2, 1'b0, 1'b0}, '{8'h82, 4'h1, 4'h2, 8'hA2, 1'b1, 1'b0},
        '{8'h93, 4'h0, 4'h2, 8'hA2, 1'b0, 1'b0}, '{8'h00, 4'h4, 4'h3, 8'hA3, 1'b0, 1'b1}};

    adc_parallel_host_port #(.CONV_CNT(CC)) u_adc_parallel_host_port (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .host_pins(pins), .result_bus_out(res_out),
        .result_bus_oe_n(oe_n), .busy_n(busy_n), .mode_pin(mode_pin), .conv_result(conv_result),
        .front(front));
    host_model u_host_model (.hclk(hclk), .pins(pins), .dev_bus(res_out), .dev_oe_n(oe_n));

    // Free-running clock at 50 MHz.
    initial begin
        forever #10 hclk = ~hclk;
    end

    // The converter answers with its channel number so results show where they land.
    always @(posedge hclk) begin
        conv_result <= 8'hA0 | {5'h00, front.channel};
        cyc <= cyc + 1;
        if (cyc == CEIL) begin
            error_cnt++;
            end_of_test();
        end
    end

    // Levels are counted mid-cycle, away from the edge that launches them, so no count races the design.
    always @(negedge hclk) begin
        busy_cyc <= busy_cyc + int'(busy_n === 1'b0);
        pair_cyc <= pair_cyc + int'(busy_n === 1'b0 && front.pair === 1'b1);
        sig_cyc <= sig_cyc + int'(busy_n === 1'b0 && front.signed_rng === 1'b1);
        hold_cnt <= hold_cnt + int'(front.hold === 1'b1);
    end

    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", n, exp, seen);
        end
    endtask

    task automatic end_of_test();
        if (error_cnt == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Single AHB-Lite word transfer; no wait count is assumed on either phase.
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rdat = hrdata;
        @(negedge hclk);
    endtask

    // Bounded wait for the end of a conversion; a hang shows up in the later checks.
    task automatic settle();
        int n;
        n = 0;
        while (busy_n !== 1'b1 && n < 500) begin
            @(posedge hclk);
            n++;
        end
        repeat (2) @(posedge hclk);
    endtask

    // A small slack allows for the edge at which busy is launched and dropped.
    task automatic bchk(input int n);
        chk("busy cycles", 32'((busy_cyc - b0 - n * CC) inside {[0:2]}), 32'h1);
    endtask

    task automatic reset_run();
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (12) @(posedge hclk);
        chk("busy at reset", busy_n, 1'b1);
        chk("enable at reset", oe_n, 1'b1);
        chk("irq at reset", irq, 1'b0);
        chk("bus response", {hreadyout, hresp}, 32'h2);
        hresetn <= 1'b1;
        repeat (5) @(posedge hclk);
    endtask

    initial begin
        reset_run();
        foreach (rows[i]) begin
            b0 = busy_cyc;
            h0 = hold_cnt;
            p0 = pair_cyc;
            s0 = sig_cyc;
            u_host_model.wr(rows[i].wb, 1'b0);
            settle();
            chk("hold pulses", hold_cnt - h0, 1);
            bchk(rows[i].n);
            chk("pair", pair_cyc != p0, rows[i].pr);
            chk("signed range", sig_cyc != s0, rows[i].sg);
            ahb(1'b0, OFF_RESULT + {2'b00, rows[i].loc, 2'b00}, 32'h0);
            chk("result", rdat, {24'h0, rows[i].exp});
            chk("bus enable", oe_n, 1'b1);
        end
        // Sequential reads restart at location 0 after the all-channel start.
        for (int i = 0; i < 4; i++) begin
            u_host_model.rd(d);
            chk("read data", d, 8'hA0 | 8'(i));
        end
        // A suppressed write loads the read address and the configuration of channel 2.
        u_host_model.wr(8'h12, 1'b0);
        u_host_model.rd(d);
        chk("addressed read", d, 8'hA2);
        u_host_model.rd(d);
        chk("next read", d, 8'hA3);
        // Strobes without chip select leave no trace; selected suppressed writes then set and clear sleep.
        b0 = busy_cyc;
        h0 = hold_cnt;
        u_host_model.wr(8'h80, 1'b1);
        settle();
        chk("unselected hold", hold_cnt - h0, 0);
        bchk(0);
        u_host_model.wr(8'h18, 1'b0);
        chk("sleep on", front.sleep, 1'b1);
        u_host_model.wr(8'h10, 1'b0);
        chk("sleep off", front.sleep, 1'b0);
        // Done event: raised, masked, unmasked and cleared.
        ahb(1'b0, OFF_STATUS, 32'h0);
        chk("done status", rdat[IRQ_DONE], 1'b1);
        chk("masked irq", irq, 1'b0);
        ahb(1'b1, OFF_MASK, 32'h1);
        chk("unmasked irq", irq, 1'b1);
        ahb(1'b1, OFF_STATUS, 32'h1);
        chk("cleared irq", irq, 1'b0);
        ahb(1'b0, 8'h40, 32'h0);
        chk("unmapped", rdat, 32'h0);
        // Wired strap: one write converts every channel.
        mode_pin <= 1'b1;
        reset_run();
        ahb(1'b0, OFF_STATE, 32'h0);
        chk("mode", rdat[ST_MODE_BIT], 1'b1);
        // The wired pair selection applies to every channel of the very next start.
        ahb(1'b1, OFF_WIRED, 32'h1);
        b0 = busy_cyc;
        p0 = pair_cyc;
        u_host_model.wr(8'h00, 1'b0);
        settle();
        bchk(CHANNELS_ALL);
        chk("wired pair", pair_cyc - p0, CHANNELS_ALL * CC);
        ahb(1'b0, OFF_RESULT + 8'h1C, 32'h0);
        chk("last channel", rdat, 32'hA7);
        end_of_test();
    end
endmodule
